//--- design/line_buffer_pkg.sv
/*
  constants for the line buffer status and interrupt block: register indices,
  field positions, reset values and the empty thresholds.
  assumes a 32-bit apb bus where each register index maps to byte address index*4.
*/
package line_buffer_pkg;
  localparam int unsigned ADDR_W            = 16;
  localparam int unsigned DATA_W            = 32;
  localparam int unsigned REG_W             = 16;
  localparam int unsigned LEVEL_W           = 16;
  localparam int unsigned COND_N            = 3;
  // register indices, byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CODEC_CONTROL = 16'h0980;
  localparam logic [ADDR_W-1:0] IDX_RESERVED_GAP  = 16'h09bc;
  localparam logic [ADDR_W-1:0] IDX_MASKED_FLAGS  = 16'h09c0;
  localparam logic [ADDR_W-1:0] IDX_RAW_FLAGS     = 16'h09c2;
  localparam logic [ADDR_W-1:0] IDX_LIVE_STATUS   = 16'h09c4;
  localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLES   = 16'h09c6;
  localparam int unsigned       BYTE_SHIFT        = 2;
  // condition bit positions, shared by all flag registers
  localparam int unsigned BIT_EMPTY         = 0;
  localparam int unsigned BIT_HALF          = 1;
  localparam int unsigned BIT_FULL          = 2;
  // codec operating mode field
  localparam int unsigned MODE_LSB          = 1;
  localparam int unsigned MODE_MSB          = 3;
  localparam logic [MODE_MSB-MODE_LSB:0] MODE_OFF = 3'h0;
  // reset values
  localparam logic [COND_N-1:0] LIVE_RESET  = 3'h1;
  localparam logic [3:0]        LIVE_TOP_ONES = 4'hf;
  localparam logic [REG_W-1:0]  LIVE_RESET_WORD = 16'hf001;
  localparam logic [COND_N-1:0] FLAGS_RESET = 3'h0;
  localparam logic [MODE_MSB-MODE_LSB:0] MODE_RESET = 3'h0;
  // empty thresholds in bytes
  localparam logic [LEVEL_W-1:0] EMPTY_LIMIT_422 = 16'h0010;
  localparam logic [LEVEL_W-1:0] EMPTY_LIMIT_420 = 16'h0008;
endpackage

//--- design/line_buffer_cond.sv
/*
  condition detector: turns the buffer fill level and the datapath's full and
  half-full indications into the three live conditions.
  assumes all inputs come from logic on pclk, so they are used unsynchronised.
*/
`timescale 1ns/1ns
module line_buffer_cond
(
  input  wire logic                                 buf_full,
  input  wire logic                                 buf_half,
  input  wire logic [line_buffer_pkg::LEVEL_W-1:0]  buf_level,
  input  wire logic                                 fmt_420,
  output logic      [line_buffer_pkg::COND_N-1:0]   cond
);
  import line_buffer_pkg::*;

  // empty threshold depends on the sample format
  always_comb begin
    cond            = '0;
    cond[BIT_FULL]  = buf_full;
    cond[BIT_HALF]  = buf_half;
    cond[BIT_EMPTY] = fmt_420 ? (buf_level <= EMPTY_LIMIT_420)
                              : (buf_level <= EMPTY_LIMIT_422);
  end
endmodule

//--- design/line_buffer_status_irq.sv
/*
  line buffer status and interrupt block with an apb slave register file.
  assumes the buffer datapath runs on pclk and drives level, full, half and format.
*/
// Operation
// - full flag bit 2, gated by enable
// - half-full flag bit 1, gated by enable
// - empty means at most 16/8 bytes
// - empty flag bit 0, gated by enable
// - flags valid only with nonzero codec mode
// - write one clears full once not full
// - write one clears half once not half
// - write one clears empty once not empty
// - raw latched flags ignore the enables
// - raw flags clear only via masked write
// - live status bits independent of enables
// - live status reads f001 after reset
// - enable bits 2..0, one enables
`timescale 1ns/1ns
module line_buffer_status_irq
(
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [line_buffer_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [line_buffer_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic      [line_buffer_pkg::DATA_W-1:0]   prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 buf_full,
  input  wire logic                                 buf_half,
  input  wire logic [line_buffer_pkg::LEVEL_W-1:0]  buf_level,
  input  wire logic                                 fmt_420,
  output logic                                      irq
);
  import line_buffer_pkg::*;

  logic [COND_N-1:0]           cond;
  logic [COND_N-1:0]           live_q;
  logic [COND_N-1:0]           raw_q;
  logic [COND_N-1:0]           raw_d;
  logic [COND_N-1:0]           en_q;
  logic [MODE_MSB-MODE_LSB:0]  mode_q;
  logic [DATA_W-1:0]           prdata_q;
  logic [DATA_W-1:0]           rdata_d;
  logic                        pready_q;
  logic                        pslverr_q;
  logic                        irq_q;
  logic                        mapped;
  logic                        access;
  logic                        wr_fire;
  logic                        wr_lo;
  logic [ADDR_W-1:0]           idx;
  logic [COND_N-1:0]           clr_req;
  logic                        mode_on;

  line_buffer_cond u_cond (
    .buf_full  (buf_full),
    .buf_half  (buf_half),
    .buf_level (buf_level),
    .fmt_420   (fmt_420),
    .cond      (cond)
  );

  // address decode: byte address carries the register index shifted by two
  assign idx     = {{BYTE_SHIFT{1'b0}}, paddr[ADDR_W-1:BYTE_SHIFT]};
  assign access  = psel & penable;
  assign wr_fire = access & pready_q & pwrite;
  assign wr_lo   = wr_fire & pstrb[0];
  assign mode_on = (mode_q != MODE_OFF);

  always_comb begin
    mapped = 1'b0;
    case (idx)
      IDX_CODEC_CONTROL,
      IDX_RESERVED_GAP,
      IDX_MASKED_FLAGS,
      IDX_RAW_FLAGS,
      IDX_LIVE_STATUS,
      IDX_IRQ_ENABLES: begin
        mapped = paddr[BYTE_SHIFT-1:0] == '0;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read mux; the reserved gap word reads zero and ignores writes
  always_comb begin
    rdata_d = '0;
    case (idx)
      IDX_CODEC_CONTROL: begin
        rdata_d[MODE_MSB:MODE_LSB] = mode_q;
      end
      IDX_MASKED_FLAGS: begin
        rdata_d[COND_N-1:0] = raw_q & en_q;
      end
      IDX_RAW_FLAGS: begin
        rdata_d[COND_N-1:0] = raw_q;
      end
      IDX_LIVE_STATUS: begin
        rdata_d[REG_W-1:REG_W-4] = LIVE_TOP_ONES;
        rdata_d[COND_N-1:0]      = live_q;
      end
      IDX_IRQ_ENABLES: begin
        rdata_d[COND_N-1:0] = en_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // apb answer: one wait state, pready high in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      if (access & ~pready_q & ~pwrite & mapped) begin
        prdata_q <= rdata_d;
      end else if (access & ~pready_q) begin
        prdata_q <= '0;
      end
    end
  end

  // codec mode field, written only through the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RESET;
    end else if (wr_lo && mapped && idx == IDX_CODEC_CONTROL) begin
      mode_q <= pwdata[MODE_MSB:MODE_LSB];
    end
  end

  // interrupt enables; a write to the gap word is decoded but dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= FLAGS_RESET;
    end else if (wr_lo && mapped && idx == IDX_IRQ_ENABLES) begin
      en_q <= pwdata[COND_N-1:0];
    end
  end

  // live conditions, registered so the read sees a stable copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q <= LIVE_RESET;
    end else begin
      live_q <= cond;
    end
  end

  // clear requests accepted only where the condition has gone away
  always_comb begin
    clr_req = '0;
    if (wr_lo && mapped && idx == IDX_MASKED_FLAGS) begin
      clr_req[BIT_FULL]  = pwdata[BIT_FULL] & ~cond[BIT_FULL];
      clr_req[BIT_HALF]  = pwdata[BIT_HALF] & ~cond[BIT_HALF];
      clr_req[BIT_EMPTY] = pwdata[BIT_EMPTY] & ~cond[BIT_EMPTY];
    end
  end

  // latched flags: set while condition holds in a valid mode, set beats clear
  always_comb begin
    raw_d = (raw_q & ~clr_req) | (cond & {COND_N{mode_on}});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q <= FLAGS_RESET;
    end else begin
      raw_q <= raw_d;
    end
  end

  // one level interrupt from the enabled latched flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(raw_d & en_q);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
endmodule

//--- sim/lbs_chk.sv
/* port checker for the line buffer status block.
   assumes byte address = register index * 4. */
`timescale 1ns/1ns
module lbs_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        buf_full,
  input wire logic        buf_half,
  input wire logic [15:0] buf_level,
  input wire logic        fmt_420,
  input wire logic        irq
);
  logic emp;
  logic live_rd;
  // empty condition and live status read strobe
  assign emp = buf_level <= (fmt_420 ? 16'h0008 : 16'h0010);
  assign live_rd = pready && !pwrite && paddr == 16'h2710;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("ready missing");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper half set");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  a_gap_okay: assert property (pready && paddr == 16'h26f0 |-> !pslverr && prdata == 32'h0)
    else $error("gap word wrong");
  a_live_fixed: assert property (live_rd |-> prdata[15:3] == 13'h1e00)
    else $error("live fixed bits wrong");
  a_live_bits: assert property (live_rd |->
    prdata[2:0] == {$past(buf_full, 2), $past(buf_half, 2), $past(emp, 2)})
    else $error("live bits wrong");
  a_irq_fall: assert property ($fell(irq) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("irq fell without write");
  a_irq_rise: assert property ($rose(irq) |->
    $past(buf_full || buf_half || emp || pready && pwrite) || $past(pready && pwrite, 2))
    else $error("irq rose alone");
endmodule
bind line_buffer_status_irq lbs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .buf_full, .buf_half, .buf_level, .fmt_420, .irq);

//--- sim/tb.sv
/* register-level bench for the line buffer status block.
   assumes the checker is bound from its own file. */
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        buf_full, buf_half, fmt_420, err;
  logic [15:0] paddr, buf_level;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          n_fail, checked;
  localparam logic [15:0] CTL = 16'h2600, MSK = 16'h2700, RAW = 16'h2708;
  localparam logic [15:0] LIV = 16'h2710, ENA = 16'h2718, GAP = 16'h26f0;
  line_buffer_status_irq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .buf_full, .buf_half, .buf_level,
    .fmt_420, .irq);
  // one apb transfer, waits for pready
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      $display("[FAIL] pready expected 1 seen %b", pready);
      n_fail++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);  // idle edge before the next setup
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task close_out;
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // clock
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  // watchdog
  initial begin
    #20000;
    n_fail++;
    close_out;
  end
  // test sequence
  initial begin
    {presetn, psel, penable, pwrite, buf_full, buf_half, fmt_420} = 7'h0;
    {paddr, pwdata, buf_level, pstrb} = {16'h0, 32'h0, 16'h0, 4'hf};
    n_fail = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdc("live", LIV, 32'hf001);
    rdc("enables", ENA, 32'h0);
    buf_full <= 1;
    buf_level <= 16'h0011;
    rdc("raw mode off", RAW, 32'h0);
    rdc("live full", LIV, 32'hf004);
    bus(1, CTL, 32'h2);
    rdc("mode", CTL, 32'h2);
    bus(1, ENA, 32'h4);
    rdc("enables", ENA, 32'h4);
    rdc("raw", RAW, 32'h4);
    rdc("masked", MSK, 32'h4);
    chk("irq", 32'h1, irq);
    bus(1, MSK, 32'h4);
    rdc("clear refused", MSK, 32'h4);
    buf_full <= 0;
    buf_half <= 1;
    bus(1, MSK, 32'h4);
    rdc("raw cleared", RAW, 32'h2);
    chk("irq", 32'h0, irq);
    bus(1, ENA, 32'h2);
    rdc("masked half", MSK, 32'h2);
    buf_half <= 0;
    bus(1, MSK, 32'h2);
    rdc("raw half", RAW, 32'h0);
    for (int i = 0; i < 4; i++) begin
      fmt_420 <= i[1];
      buf_level <= (i[1] ? 16'h0008 : 16'h0010) + 16'(i[0]);
      rdc("live empty", LIV, {16'h0, 15'h7800, ~i[0]});
    end
    bus(1, MSK, 32'h1);
    rdc("raw empty", RAW, 32'h0);
    bus(1, ENA, 32'h1);
    buf_level <= 16'h0;
    bus(1, MSK, 32'h1);
    rdc("masked empty", MSK, 32'h1);
    chk("irq", 32'h1, irq);
    rdc("gap", GAP, 32'h0); // read only, the gap word is never written
    bus(0, 16'h2004, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    pstrb <= 4'h0;
    bus(1, ENA, 32'h0);
    pstrb <= 4'hf;
    rdc("strobe off", ENA, 32'h1);
    close_out;
  end
endmodule
